// File: rtl/gdsc_pkg.sv
// Package of shared timing constants for the gate driver short-circuit supervisor.
// Assumes a single 20 MHz core clock; every count below is derived from that rate.
package gdsc_pkg;
  // Core clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Qualification delay after a turn-on command; a least time, so it rounds up.
  localparam int unsigned QUAL_DELAY_NS = 8500;
  localparam int unsigned QUAL_CYC = (QUAL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Dark acknowledge pulse on every command edge; treated as a least time.
  localparam int unsigned ACK_PULSE_NS = 900;
  localparam int unsigned ACK_CYC = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Fault latch interval of one second, expressed in milliseconds.
  localparam int unsigned FAULT_HOLD_MS = 1000;
  localparam int unsigned FAULT_CYC = FAULT_HOLD_MS * (1000000 / CLK_PERIOD_NS);
  // Counter width that covers the longest interval.
  localparam int unsigned TMR_W = 25;
  // Reset values of the registered gate and status outputs.
  localparam logic GATE_RST = 1'h0;
  localparam logic STATUS_RST = 1'h0;
endpackage

// File: rtl/gdsc_tmr_if.sv
// Interface between the supervisor and its one-shot interval timers.
// Assumes both ends share the core clock; start is a one-cycle pulse, abort may be held as a level.
`timescale 1ns/1ps
`default_nettype none
interface gdsc_tmr_if #(
  parameter int unsigned W = 25
);
  logic start;
  logic abort;
  logic [W-1:0] load;
  logic busy;
  logic done;
  modport ctrl (output start, output abort, output load, input busy, input done);
  modport timer (input start, input abort, input load, output busy, output done);
endinterface
`default_nettype wire

// File: rtl/gdsc_timer.sv
// One-shot down-counting interval timer used for every delay of the supervisor.
// Assumes a synchronous active-high reset; done pulses exactly load cycles after start.
`timescale 1ns/1ps
`default_nettype none
module gdsc_timer #(
  parameter int unsigned W = 25
) (
  input wire logic clk_i,
  input wire logic rst_i,
  gdsc_tmr_if.timer tmr
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Start reloads even while running, so a retrigger restarts the interval.
  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.start) begin
      cnt_nxt = tmr.load;
    end else if (tmr.abort) begin
      cnt_nxt = '0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done marks the last counted cycle; an abort in that cycle suppresses it.
  assign tmr.busy = (cnt_r != '0);
  assign tmr.done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !tmr.abort && !tmr.start;
endmodule
`default_nettype wire

// File: rtl/gdsc_supervisor.sv
// Short-circuit supervisor and command sequencer of a single-channel gate driver.
// Assumes all inputs are synchronous to clk_i and the comparator threshold is fixed in analog.
`timescale 1ns/1ps
`default_nettype none
module gdsc_supervisor #(
  parameter int unsigned FAULT_CYCLES = gdsc_pkg::FAULT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_light_i,
  input wire logic vce_high_i,
  input wire logic undervoltage_i,
  input wire logic mode_select_jumper_i,
  output logic gate_on_o,
  output logic status_light_o,
  output logic fault_o
);
  localparam int unsigned W = gdsc_pkg::TMR_W;

  gdsc_tmr_if #(.W(W)) qual_tmr ();
  gdsc_tmr_if #(.W(W)) fault_tmr ();
  gdsc_tmr_if #(.W(W)) ack_tmr ();

  // All three intervals share one counter design, all cleared by reset.
  gdsc_timer #(.W(W)) u_qual (.clk_i(clk_i), .rst_i(rst_i), .tmr(qual_tmr));
  gdsc_timer #(.W(W)) u_fault (.clk_i(clk_i), .rst_i(rst_i), .tmr(fault_tmr));
  gdsc_timer #(.W(W)) u_ack (.clk_i(clk_i), .rst_i(rst_i), .tmr(ack_tmr));

  logic cmd_prev_r;
  logic cmd_prev_nxt;
  logic armed_r;
  logic armed_nxt;
  logic fault_r;
  logic fault_nxt;
  logic gate_r;
  logic gate_nxt;
  logic status_r;
  logic status_nxt;
  logic cmd_rise;
  logic cmd_edge;
  logic indep_mode;
  logic sc_detect;

  // Jumper high means position 1-2, the autonomous shutdown mode.
  assign indep_mode = mode_select_jumper_i;
  assign cmd_rise = cmd_light_i && !cmd_prev_r;
  assign cmd_edge = cmd_light_i ^ cmd_prev_r;

  // Timer requests; a falling command abandons a pending qualification.
  assign qual_tmr.start = cmd_rise;
  assign qual_tmr.abort = !cmd_light_i;
  assign qual_tmr.load = W'(gdsc_pkg::QUAL_CYC);
  assign ack_tmr.start = cmd_edge;
  assign ack_tmr.abort = 1'b0;
  assign ack_tmr.load = W'(gdsc_pkg::ACK_CYC);
  assign fault_tmr.start = sc_detect;
  assign fault_tmr.abort = 1'b0;
  assign fault_tmr.load = W'(FAULT_CYCLES);

  // The comparator itself encodes the fixed threshold, so a high level is the fault.
  // It is looked at only at the qualification instant and while armed afterwards,
  // never during the switching transient. Overcurrent is deliberately not judged here.
  always_comb begin
    sc_detect = 1'b0;
    if (!fault_r && cmd_light_i && vce_high_i) begin
      sc_detect = qual_tmr.done || armed_r;
    end
  end

  // Next state of the sequencing flags and the registered outputs.
  always_comb begin
    cmd_prev_nxt = cmd_light_i;
    armed_nxt = armed_r;
    if (!cmd_light_i) begin
      armed_nxt = 1'b0;
    end else if (qual_tmr.done) begin
      armed_nxt = 1'b1;
    end
    fault_nxt = fault_r;
    if (sc_detect) begin
      fault_nxt = 1'b1;
    end else if (fault_tmr.done) begin
      fault_nxt = 1'b0;
    end
    // Light on, no undervoltage, and no latched fault in independent mode.
    gate_nxt = cmd_light_i && !undervoltage_i;
    if (indep_mode && (fault_r || sc_detect)) begin
      gate_nxt = 1'b0;
    end
    // Dark on fault, on any edge acknowledge, and on undervoltage as a malfunction.
    status_nxt = !(fault_nxt || cmd_edge || ack_tmr.busy || undervoltage_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_prev_r <= 1'b0;
      armed_r <= 1'b0;
      fault_r <= 1'b0;
      gate_r <= gdsc_pkg::GATE_RST;
      status_r <= gdsc_pkg::STATUS_RST;
    end else begin
      cmd_prev_r <= cmd_prev_nxt;
      armed_r <= armed_nxt;
      fault_r <= fault_nxt;
      gate_r <= gate_nxt;
      status_r <= status_nxt;
    end
  end

  assign gate_on_o = gate_r;
  assign status_light_o = status_r;
  assign fault_o = fault_r;

  // Helper state for the assertions only; it drives no output and is trimmed away in silicon.
  // Counting intervals here keeps the properties free of long repetitions.
  // The on counter holds cycles since the latest rising command edge and saturates.
  // The quiet counter holds cycles since the latest command edge of either sense.
  // The hold counter holds consecutive cycles with the fault latched.
  logic [7:0] on_cnt_r;
  logic [7:0] on_cnt_nxt;
  logic [7:0] quiet_cnt_r;
  logic [7:0] quiet_cnt_nxt;
  logic [W-1:0] hold_cnt_r;
  logic [W-1:0] hold_cnt_nxt;

  always_comb begin
    on_cnt_nxt = on_cnt_r;
    if (!cmd_light_i) begin
      on_cnt_nxt = 8'h00;
    end else if (cmd_rise) begin
      on_cnt_nxt = 8'h01;
    end else if (on_cnt_r != 8'hff) begin
      on_cnt_nxt = on_cnt_r + 8'h01;
    end
    quiet_cnt_nxt = quiet_cnt_r;
    if (cmd_edge) begin
      quiet_cnt_nxt = 8'h00;
    end else if (quiet_cnt_r != 8'hff) begin
      quiet_cnt_nxt = quiet_cnt_r + 8'h01;
    end
    hold_cnt_nxt = '0;
    if (fault_r) begin
      hold_cnt_nxt = hold_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_cnt_r <= 8'h00;
      quiet_cnt_r <= 8'h00;
      hold_cnt_r <= '0;
    end else begin
      on_cnt_r <= on_cnt_nxt;
      quiet_cnt_r <= quiet_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  a_gate_uv_block: assert property (@(posedge clk_i) disable iff (rst_i)
    undervoltage_i |=> !gate_on_o) else $error("Gate on during undervoltage.");
  a_gate_off_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    !cmd_light_i |=> !gate_on_o) else $error("Gate on without command light.");
  a_gate_follow_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_light_i && !undervoltage_i && !fault_r && !sc_detect |=> gate_on_o)
    else $error("Gate failed to follow command.");
  a_indep_fault_off: assert property (@(posedge clk_i) disable iff (rst_i)
    indep_mode && fault_r |=> !gate_on_o) else $error("Gate on during latched fault.");
  a_host_keeps_on: assert property (@(posedge clk_i) disable iff (rst_i)
    !indep_mode && fault_r && cmd_light_i && !undervoltage_i |=> gate_on_o)
    else $error("Host mode gate dropped on fault.");
  a_fault_status_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_r |-> !status_light_o) else $error("Status lit during fault latch.");
  a_edge_ack_dark: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(cmd_light_i) |=> !status_light_o [*8]) else $error("Edge acknowledge too short.");
  a_no_early_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(fault_r) |-> on_cnt_r > 8'(gdsc_pkg::QUAL_CYC))
    else $error("Fault before qualification.");
  a_qual_sample: assert property (@(posedge clk_i) disable iff (rst_i)
    qual_tmr.done && cmd_light_i && vce_high_i |=> fault_r) else $error("Missed short circuit.");
  a_latch_release: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_r && fault_tmr.done |=> !fault_r) else $error("Fault not released at expiry.");
  a_fault_held: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_r && fault_tmr.busy && !fault_tmr.done |=> fault_r) else $error("Fault dropped early.");
  // The shutdown path is bounded: qualification ends 170 cycles after the rising edge and the
  // gate falls one cycle later, inside the maximum short-circuit response delay.
  a_qual_instant: assert property (@(posedge clk_i) disable iff (rst_i)
    qual_tmr.done == (cmd_light_i && on_cnt_r == 8'(gdsc_pkg::QUAL_CYC)))
    else $error("Qualification instant misplaced.");
  a_resp_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    indep_mode && qual_tmr.done && vce_high_i |=> !gate_on_o)
    else $error("Gate still on after qualified short circuit.");
  // Once armed in independent mode, a short circuit in the on state trips the gate at the next edge.
  a_armed_trip: assert property (@(posedge clk_i) disable iff (rst_i)
    indep_mode && armed_r && cmd_light_i && vce_high_i |=> !gate_on_o)
    else $error("Gate on after on-state short circuit.");
  // The latch must last exactly the configured interval, not one cycle more or less.
  a_fault_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(fault_r) |-> hold_cnt_r == W'(FAULT_CYCLES))
    else $error("Fault latch interval wrong.");
  // Quiet command, no undervoltage: either the status is lit or a fault is being reported.
  a_status_quiet_lit: assert property (@(posedge clk_i) disable iff (rst_i)
    quiet_cnt_r > 8'(gdsc_pkg::ACK_CYC) && $stable(cmd_light_i) && !undervoltage_i
    |=> status_light_o || fault_o)
    else $error("Status dark without cause.");
endmodule
`default_nettype wire

// File: verif/gdsc_host_model.sv
// Host controller model that owns the command fiber and watches the status fiber.
// Assumes the bench states when it wants the switch on and whether to react to faults.
`timescale 1ns/1ps
`default_nettype none
module gdsc_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_on_i,
  input wire logic react_i,
  input wire logic status_light_i,
  output logic cmd_light_o
);
  logic [7:0] dark_r;
  logic block_r;
  // A dark spell a few cycles longer than the edge acknowledge is read as a fault report.
  // A retriggered acknowledge can stretch the dark time, so the margin must stay small but real.
  always_ff @(posedge clk_i) begin
    if (rst_i || status_light_i) begin
      dark_r <= 8'h00;
    end else if (dark_r != 8'hff) begin
      dark_r <= dark_r + 8'h01;
    end
    if (rst_i || !want_on_i) begin
      block_r <= 1'h0;
    end else if (react_i && dark_r > 8'(gdsc_pkg::ACK_CYC) + 8'h04) begin
      block_r <= 1'h1;
    end
  end
  // When react_i is set, the host turns the switch off itself once it has seen a fault report.
  assign cmd_light_o = want_on_i && !block_r;
endmodule
`default_nettype wire

// File: verif/gate_driver_short_circuit_supervisor_bench.sv
// Self-checking bench of the short-circuit supervisor with a host model on the fibers.
// Assumes a shortened fault latch; notes are compared at the falling edge of their cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %b want %b", $time, a, b); end end
module gate_driver_short_circuit_supervisor_bench;
  localparam int FC = 50;
  typedef struct {int c; logic [2:0] v;} gdsc_note_t;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic want = 1'h0;
  logic react = 1'h0;
  logic collector_emitter_voltage = 1'h0;
  logic uv = 1'h0;
  logic jmp = 1'h1;
  logic cmd, gate, status, fault;
  int cyc = 0;
  int fails = 0;
  int total_checks = 0;
  gdsc_note_t q[$];
  always #25 clk_i = ~clk_i;
  gdsc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .want_on_i(want), .react_i(react),
    .status_light_i(status), .cmd_light_o(cmd));
  gdsc_supervisor #(.FAULT_CYCLES(FC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cmd_light_i(cmd),
    .vce_high_i(collector_emitter_voltage), .undervoltage_i(uv), .mode_select_jumper_i(jmp), .gate_on_o(gate),
    .status_light_o(status), .fault_o(fault));
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  // Note the expected gate, status and fault d cycles ahead, then let them pass.
  task automatic see(int d, logic [2:0] v);
    q.push_back('{cyc + d, v});
    step(d);
  endtask
  // Cycle count with a ceiling well above the planned run, so a hang cannot go on.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      fails++;
      print_verdict();
    end
  end
  // The falling edge is far from both launch and sampling, so outputs are settled.
  always @(negedge clk_i) begin
    while (q.size() > 0 && q[0].c == cyc) begin
      `CHK({gate, status, fault}, q[0].v)
      void'(q.pop_front());
    end
  end
  initial begin
    void'($urandom(8));
    step(12);
    rst_i = 1'h0;
    see(25, 3'b010);
    // Independent mode: comparator noise before the sampling instant must be ignored.
    want = 1'h1;
    see(3, 3'b100);
    for (int i = 0; i < 150; i++) begin
      collector_emitter_voltage = 1'($urandom);
      step(1);
    end
    collector_emitter_voltage = 1'h0;
    see(40, 3'b110);
    collector_emitter_voltage = 1'h1;
    see(3, 3'b001);
    collector_emitter_voltage = 1'h0;
    want = 1'h0;
    step(2);
    want = 1'h1;
    see(10, 3'b001);
    want = 1'h0;
    see(45, 3'b010);
    want = 1'h1;
    see(3, 3'b100);
    want = 1'h0;
    see(25, 3'b010);
    // Host-directed mode: report only, the host model then turns the switch off.
    jmp = 1'h0;
    react = 1'h1;
    want = 1'h1;
    step(160);
    collector_emitter_voltage = 1'h1;
    see(15, 3'b101);
    see(40, 3'b001);
    collector_emitter_voltage = 1'h0;
    want = 1'h0;
    react = 1'h0;
    step(60);
    // Undervoltage blocks turn-on and darkens the status.
    uv = 1'h1;
    want = 1'h1;
    see(5, 3'b000);
    see(30, 3'b000);
    want = 1'h0;
    uv = 1'h0;
    step(3);
    print_verdict();
  end
endmodule
`default_nettype wire
